// File: src/pmu_ctrl.sv
// Power mode controller with regulator and battery monitor registers
//
// Notes on behaviour
// - Registers decode in 0x0048..0x004C; analog, digital, battery bytes at first three.
// - Analog byte: bits 7:6 read zero, trim default bit resets one, trim resets 0011.
// - Analog bit 4 resets zero; outside OFF write one switches analog supply on, zero off; in OFF it is held zero.
// - Digital bit 7 reads the synchronised wake pin level; resets zero.
// - Digital bit 4 shows digital supply on, resets one; trim 3:2 resets 00.
// - Digital bit 1 write-only; writing zero shuts digital supply; 6:5 and 0 read zero.
// - Battery bit 7 reads the synchronised comparator output, one when at or above threshold.
// - Battery bit 5 resets zero and switches the comparator on or off; bit 6 zero.
// - Battery bits 4:0 reset zero and set the comparator threshold code.
// - Three modes; in OFF every internal supply is shut down.
// - ON is entered when wake goes high, left only by software request.
// - In ON codec and analog unpowered; digital supply on, analog supply off.
// - AUDIO entered on request; codec and analog powered, both supplies on.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmu_ctrl #(
  parameter int EOL_START_CYC = pmu_pkg::EOL_START_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [pmu_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pmu_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [pmu_pkg::DATA_W-1:0] bus_rdata,
  input wire logic wake_pin,
  input wire logic battery_cmp_in,
  output logic analog_supply_out_en,
  output logic analog_trim_default,
  output logic [pmu_pkg::ANA_TRIM_W-1:0] analog_regulator_trim,
  output logic digital_supply_out_en,
  output logic [pmu_pkg::DIG_TRIM_W-1:0] digital_regulator_trim,
  output logic codec_power_en,
  output logic battery_monitor_en,
  output logic [pmu_pkg::BAT_THR_W-1:0] battery_threshold_code,
  output pmu_pkg::pmu_mode_e power_mode,
  output logic irq
);
  import pmu_pkg::*;

  typedef struct packed {
    logic ana_def;
    logic ana_on;
    logic [ANA_TRIM_W-1:0] ana_trim;
    logic [DIG_TRIM_W-1:0] dig_trim;
    logic bat_on;
    logic [BAT_THR_W-1:0] bat_thr;
    pmu_mode_e mode;
    logic ana_en;
    logic dig_en;
    logic codec_en;
    logic wake_d;
    logic bat_d;
    logic [CNT_W-1:0] settle;
    logic [DATA_W-1:0] rdata;
  } pmu_ctrl_s;

  localparam logic [CNT_W-1:0] START_CNT = CNT_W'(EOL_START_CYC);
  localparam logic [CNT_W-1:0] RES_CNT = CNT_W'(EOL_RES_CYC);

  pmu_ctrl_s st_r;
  pmu_ctrl_s st_nxt;
  logic wake_lvl;
  logic bat_lvl;
  logic wake_rise;
  logic wr_ana;
  logic wr_dig;
  logic wr_bat;
  logic hold_off;
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] irq_status;
  logic [EV_N-1:0] irq_mask;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  pmu_sync #(
    .W(2)
  ) pmu_sync_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in({wake_pin, battery_cmp_in}),
    .level_out({wake_lvl, bat_lvl})
  );

  // ************************************************************
  // Decode
  // ************************************************************
  // address decode
  assign wr_ana = bus_wr && (bus_addr == ADDR_ANA);
  assign wr_dig = bus_wr && (bus_addr == ADDR_DIG);
  assign wr_bat = bus_wr && (bus_addr == ADDR_BAT);
  assign hold_off = wr_dig && !bus_wdata[DIG_HOLD_BIT];
  assign wake_rise = wake_lvl && !st_r.wake_d;

  // ************************************************************
  // Registers, battery settling and mode sequencing
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    ev = '0;
    st_nxt.rdata = '0;
    st_nxt.wake_d = wake_lvl;
    st_nxt.bat_d = bat_lvl;
    if (bus_rd) begin
      case (bus_addr)
        ADDR_ANA: begin
          st_nxt.rdata[ANA_DEF_BIT] = st_r.ana_def;
          st_nxt.rdata[ANA_ON_BIT] = st_r.ana_on;
          st_nxt.rdata[ANA_TRIM_LSB +: ANA_TRIM_W] = st_r.ana_trim;
        end
        ADDR_DIG: begin
          st_nxt.rdata[DIG_WAKE_BIT] = wake_lvl;
          st_nxt.rdata[DIG_STATE_BIT] = st_r.dig_en;
          st_nxt.rdata[DIG_TRIM_LSB +: DIG_TRIM_W] = st_r.dig_trim;
        end
        ADDR_BAT: begin
          st_nxt.rdata[BAT_OK_BIT] = bat_lvl;
          st_nxt.rdata[BAT_ON_BIT] = st_r.bat_on;
          st_nxt.rdata[BAT_THR_LSB +: BAT_THR_W] = st_r.bat_thr;
        end
        ADDR_IRQ_STAT: begin
          st_nxt.rdata[EV_N-1:0] = irq_status;
        end
        ADDR_IRQ_MASK: begin
          st_nxt.rdata[EV_N-1:0] = irq_mask;
        end
        default: begin
          st_nxt.rdata = '0;
        end
      endcase
    end
    if (wr_ana) begin
      st_nxt.ana_def = bus_wdata[ANA_DEF_BIT];
      st_nxt.ana_on = bus_wdata[ANA_ON_BIT];
      st_nxt.ana_trim = bus_wdata[ANA_TRIM_LSB +: ANA_TRIM_W];
    end
    if (wr_dig) begin
      st_nxt.dig_trim = bus_wdata[DIG_TRIM_LSB +: DIG_TRIM_W];
    end
    if (wr_bat) begin
      st_nxt.bat_on = bus_wdata[BAT_ON_BIT];
      st_nxt.bat_thr = bus_wdata[BAT_THR_LSB +: BAT_THR_W];
    end
    // hold off the low-battery event while the comparator settles
    if (st_r.settle != '0) begin
      st_nxt.settle = st_r.settle - 1'b1;
    end
    if (!st_nxt.bat_on) begin
      st_nxt.settle = '0;
    end else if (!st_r.bat_on) begin
      st_nxt.settle = START_CNT;
    end else if (wr_bat && (st_nxt.bat_thr != st_r.bat_thr) && (st_r.settle < RES_CNT)) begin
      st_nxt.settle = RES_CNT;
    end
    ev[EV_BATT_LOW] = st_r.bat_on && (st_r.settle == '0) && st_r.bat_d && !bat_lvl;
    ev[EV_WAKE] = wake_rise;
    case (st_r.mode)
      // a rising edge on wake brings the chip up
      PMU_OFF: begin
        if (wake_rise) begin
          st_nxt.mode = PMU_ON;
        end
      end
      PMU_ON: begin
        if (hold_off) begin
          st_nxt.mode = PMU_OFF;
        end else if (st_nxt.ana_on) begin
          st_nxt.mode = PMU_AUDIO;
        end
      end
      PMU_AUDIO: begin
        if (hold_off) begin
          st_nxt.mode = PMU_OFF;
        end else if (!st_nxt.ana_on) begin
          st_nxt.mode = PMU_ON;
        end
      end
      default: begin
        st_nxt.mode = PMU_ON;
      end
    endcase
    // entering OFF drops every supply request
    if (st_nxt.mode == PMU_OFF) begin
      st_nxt.ana_on = 1'b0;
      st_nxt.bat_on = 1'b0;
      st_nxt.settle = '0;
    end
    ev[EV_MODE] = (st_nxt.mode != st_r.mode);
    st_nxt.dig_en = (st_nxt.mode != PMU_OFF);
    st_nxt.ana_en = (st_nxt.mode == PMU_AUDIO);
    st_nxt.codec_en = (st_nxt.mode == PMU_AUDIO);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r.ana_def <= ANA_DEF_RST;
      st_r.ana_on <= 1'b0;
      st_r.ana_trim <= ANA_TRIM_RST;
      st_r.dig_trim <= DIG_TRIM_RST;
      st_r.bat_on <= 1'b0;
      st_r.bat_thr <= BAT_THR_RST;
      st_r.mode <= PMU_ON;
      st_r.ana_en <= 1'b0;
      st_r.dig_en <= 1'b1;
      st_r.codec_en <= 1'b0;
      st_r.wake_d <= 1'b0;
      st_r.bat_d <= 1'b0;
      st_r.settle <= '0;
      st_r.rdata <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  pmu_irq #(
    .N(EV_N)
  ) pmu_irq_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ev_set(ev),
    .clr_we(bus_wr && (bus_addr == ADDR_IRQ_STAT)),
    .mask_we(bus_wr && (bus_addr == ADDR_IRQ_MASK)),
    .wdata(bus_wdata[EV_N-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign bus_rdata = st_r.rdata;
  assign analog_supply_out_en = st_r.ana_en;
  assign analog_trim_default = st_r.ana_def;
  assign analog_regulator_trim = st_r.ana_trim;
  assign digital_supply_out_en = st_r.dig_en;
  assign digital_regulator_trim = st_r.dig_trim;
  assign codec_power_en = st_r.codec_en;
  assign battery_monitor_en = st_r.bat_on;
  assign battery_threshold_code = st_r.bat_thr;
  assign power_mode = st_r.mode;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_unmapped;
    @(posedge sys_clk) disable iff (!nrst)
    (bus_rd && ((bus_addr < ADDR_ANA) || (bus_addr > ADDR_IRQ_MASK))) |=> (bus_rdata == '0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_ana_read;
    @(posedge sys_clk) disable iff (!nrst)
    (bus_rd && (bus_addr == ADDR_ANA)) |=>
      (bus_rdata == {2'b00, $past(st_r.ana_def), $past(st_r.ana_on), $past(st_r.ana_trim)});
  endproperty
  a_ana_read: assert property (p_ana_read) else $error("analog byte readback wrong");

  property p_ana_write;
    @(posedge sys_clk) disable iff (!nrst)
    (wr_ana && (st_r.mode != PMU_OFF) && !hold_off) |=> (st_r.ana_on == $past(bus_wdata[ANA_ON_BIT]));
  endproperty
  a_ana_write: assert property (p_ana_write) else $error("analog on bit not stored");

  property p_dig_read;
    @(posedge sys_clk) disable iff (!nrst)
    (bus_rd && (bus_addr == ADDR_DIG)) |=>
      (bus_rdata == {$past(wake_lvl), 2'b00, $past(st_r.dig_en), $past(st_r.dig_trim), 2'b00});
  endproperty
  a_dig_read: assert property (p_dig_read) else $error("digital byte readback wrong");

  property p_state_bit;
    @(posedge sys_clk) disable iff (!nrst)
    digital_supply_out_en == (power_mode != PMU_OFF);
  endproperty
  a_state_bit: assert property (p_state_bit) else $error("digital state not tracking mode");

  property p_hold_off;
    @(posedge sys_clk) disable iff (!nrst)
    hold_off |=> (power_mode == PMU_OFF) && !digital_supply_out_en;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("hold zero did not shut down");

  property p_bat_read;
    @(posedge sys_clk) disable iff (!nrst)
    (bus_rd && (bus_addr == ADDR_BAT)) |=>
      (bus_rdata == {$past(bat_lvl), 1'b0, $past(st_r.bat_on), $past(st_r.bat_thr)});
  endproperty
  a_bat_read: assert property (p_bat_read) else $error("battery byte readback wrong");

  property p_bat_write;
    @(posedge sys_clk) disable iff (!nrst)
    (wr_bat && (st_r.mode != PMU_OFF)) |=>
      (battery_monitor_en == $past(bus_wdata[BAT_ON_BIT])) &&
      (battery_threshold_code == $past(bus_wdata[BAT_THR_LSB +: BAT_THR_W]));
  endproperty
  a_bat_write: assert property (p_bat_write) else $error("battery control not stored");

  property p_settle;
    @(posedge sys_clk) disable iff (!nrst)
    (!st_r.bat_on && st_nxt.bat_on) |=> (st_r.settle == START_CNT);
  endproperty
  a_settle: assert property (p_settle) else $error("settle count not loaded");

  property p_off;
    @(posedge sys_clk) disable iff (!nrst)
    (power_mode == PMU_OFF) |-> !analog_supply_out_en && !codec_power_en && !battery_monitor_en;
  endproperty
  a_off: assert property (p_off) else $error("supply on in off mode");

  property p_wake;
    @(posedge sys_clk) disable iff (!nrst)
    ((power_mode == PMU_OFF) && wake_rise) |=> (power_mode == PMU_ON) && digital_supply_out_en;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not enter on mode");

  property p_on;
    @(posedge sys_clk) disable iff (!nrst)
    (power_mode == PMU_ON) |-> digital_supply_out_en && !analog_supply_out_en && !codec_power_en;
  endproperty
  a_on: assert property (p_on) else $error("on mode supplies wrong");

  property p_audio;
    @(posedge sys_clk) disable iff (!nrst)
    (power_mode == PMU_AUDIO) |-> digital_supply_out_en && analog_supply_out_en && codec_power_en;
  endproperty
  a_audio: assert property (p_audio) else $error("audio mode supplies wrong");

  property p_to_audio;
    @(posedge sys_clk) disable iff (!nrst)
    ((power_mode == PMU_ON) && wr_ana && bus_wdata[ANA_ON_BIT]) |=> (power_mode == PMU_AUDIO);
  endproperty
  a_to_audio: assert property (p_to_audio) else $error("analog on did not enter audio");

endmodule
`default_nettype wire

// File: src/pmu_irq.sv
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module pmu_irq #(
  parameter int N = 3
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [N-1:0] ev_set,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [N-1:0] wdata,
  output logic [N-1:0] status,
  output logic [N-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
    logic irq;
  } pmu_irq_s;

  pmu_irq_s st_r;
  pmu_irq_s st_nxt;
  logic [N-1:0] clr_bits;

  // ************************************************************
  // Write one to clear; a new event wins over the clear
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    clr_bits = clr_we ? wdata : '0;
    st_nxt.status = (st_r.status & ~clr_bits) | ev_set;
    if (mask_we) begin
      st_nxt.mask = wdata;
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign mask = st_r.mask;
  assign irq = st_r.irq;

  property p_set_wins;
    @(posedge sys_clk) disable iff (!nrst)
    (|ev_set) |=> ((status & $past(ev_set)) == $past(ev_set));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost against clear");

  property p_irq_level;
    @(posedge sys_clk) disable iff (!nrst)
    irq == (|(status & mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not matching masked status");

endmodule
`default_nettype wire

// File: src/pmu_pkg.sv
// Constants, register map and types of the power mode and battery monitor block
package pmu_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_ANA = 16'h0048;
  localparam logic [ADDR_W-1:0] ADDR_DIG = 16'h0049;
  localparam logic [ADDR_W-1:0] ADDR_BAT = 16'h004a;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 16'h004b;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 16'h004c;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int ANA_DEF_BIT = 5;
  localparam int ANA_ON_BIT = 4;
  localparam int ANA_TRIM_LSB = 0;
  localparam int ANA_TRIM_W = 4;
  localparam logic [ANA_TRIM_W-1:0] ANA_TRIM_RST = 4'h3;
  localparam logic ANA_DEF_RST = 1'b1;
  localparam int DIG_WAKE_BIT = 7;
  localparam int DIG_STATE_BIT = 4;
  localparam int DIG_TRIM_LSB = 2;
  localparam int DIG_TRIM_W = 2;
  localparam logic [DIG_TRIM_W-1:0] DIG_TRIM_RST = 2'h0;
  localparam int DIG_HOLD_BIT = 1;
  localparam int BAT_OK_BIT = 7;
  localparam int BAT_ON_BIT = 5;
  localparam int BAT_THR_LSB = 0;
  localparam int BAT_THR_W = 5;
  localparam logic [BAT_THR_W-1:0] BAT_THR_RST = 5'h00;

  // ************************************************************
  // Interrupt events
  // ************************************************************
  localparam int EV_WAKE = 0;
  localparam int EV_BATT_LOW = 1;
  localparam int EV_MODE = 2;
  localparam int EV_N = 3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int EOL_START_US = 100;
  localparam int EOL_RES_US = 20;
  localparam int EOL_START_CYC = EOL_START_US * CLK_MHZ;
  localparam int EOL_RES_CYC = EOL_RES_US * CLK_MHZ;
  localparam int CNT_W = 14;

  // ************************************************************
  // Power modes
  // ************************************************************
  typedef enum logic [2:0] {
    PMU_OFF = 3'b001,
    PMU_ON = 3'b010,
    PMU_AUDIO = 3'b100
  } pmu_mode_e;

endpackage

// File: src/pmu_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pmu_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } pmu_sync_s;

  pmu_sync_s st_r;
  pmu_sync_s st_nxt;

  // ************************************************************
  // Level follows only where the last two stages agree
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.lvl = (st_r.s3 & ~(st_r.s2 ^ st_r.s3)) | (st_r.lvl & (st_r.s2 ^ st_r.s3));
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.lvl;

  property p_sync_agree;
    @(posedge sys_clk) disable iff (!nrst)
    (st_r.s2 == st_r.s3) |=> (st_r.lvl == $past(st_r.s3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync level not following stages");

endmodule
`default_nettype wire

// File: testbench/pmu_ctrl_tb_top.sv
// Self-checking testbench of the power mode and battery monitor block
`timescale 1ns/1ps
`default_nettype none
module pmu_ctrl_tb_top;
  import pmu_pkg::*;
  localparam int START_CYC = 20;
  logic sys_clk, nrst, bus_wr, bus_rd, wake_pin, battery_cmp_in;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata, d, ana_last;
  logic analog_supply_out_en, analog_trim_default, digital_supply_out_en;
  logic codec_power_en, battery_monitor_en, irq;
  logic [ANA_TRIM_W-1:0] analog_regulator_trim;
  logic [DIG_TRIM_W-1:0] digital_regulator_trim;
  logic [BAT_THR_W-1:0] battery_threshold_code;
  pmu_mode_e power_mode;
  int mismatches, tests_run, seed_dummy;

  pmu_ctrl #(.EOL_START_CYC(START_CYC)) pmu_ctrl_inst (
    .sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .wake_pin(wake_pin),
    .battery_cmp_in(battery_cmp_in), .analog_supply_out_en(analog_supply_out_en),
    .analog_trim_default(analog_trim_default), .analog_regulator_trim(analog_regulator_trim),
    .digital_supply_out_en(digital_supply_out_en),
    .digital_regulator_trim(digital_regulator_trim), .codec_power_en(codec_power_en),
    .battery_monitor_en(battery_monitor_en), .battery_threshold_code(battery_threshold_code),
    .power_mode(power_mode), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // Bus cycles, comparisons and report
  // ************************************************************
  task automatic close_out();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input pmu_mode_e got, input pmu_mode_e exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= v;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    #1;
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    chk_val(bus_rdata, exp);
  endtask

  task automatic wait_mode(input pmu_mode_e m);
    int i;
    for (i = 0; i < 64 && power_mode !== m; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (power_mode !== m) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, power_mode, m);
      close_out();
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Expected read-back of the analog and digital bytes
  function automatic logic [7:0] ana_rd(input logic [7:0] v);
    return {2'b00, v[5:0]};
  endfunction

  function automatic logic [7:0] dig_rd(input logic wk, input logic on, input logic [7:0] v);
    return {wk, 2'b00, on, v[3:2], 2'b00};
  endfunction

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    nrst = 1'b0;
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    wake_pin = 1'b0;
    battery_cmp_in = 1'b0;
    mismatches = 0;
    tests_run = 0;
    seed_dummy = $urandom(1);
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    settle(1);
    chk_mode(power_mode, PMU_ON);
    chk_bit(digital_supply_out_en, 1'b1);
    chk_bit(analog_supply_out_en, 1'b0);
    chk_bit(analog_trim_default, 1'b1);
    chk_val({4'h0, analog_regulator_trim}, 8'h03);
    chk_bit(battery_monitor_en, 1'b0);
    chk_reg(ADDR_ANA, 8'h23);
    chk_reg(ADDR_DIG, 8'h10);
    chk_reg(ADDR_BAT, 8'h00);
    chk_reg(ADDR_IRQ_STAT, 8'h00);
    chk_reg(16'h0047, 8'h00);
    chk_reg(16'h004d, 8'h00);
    $display("test reset values done");
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom);
      d[ANA_ON_BIT] = 1'b0;
      ana_last = d;
      wr(ADDR_ANA, d);
      chk_val({4'h0, analog_regulator_trim}, {4'h0, d[3:0]});
      chk_bit(analog_trim_default, d[ANA_DEF_BIT]);
      chk_reg(ADDR_ANA, ana_rd(d));
      d = 8'($urandom);
      d[DIG_HOLD_BIT] = 1'b1;
      wr(ADDR_DIG, d);
      chk_val({6'h00, digital_regulator_trim}, {6'h00, d[3:2]});
      chk_reg(ADDR_DIG, dig_rd(1'b0, 1'b1, d));
      d = 8'($urandom);
      d[BAT_ON_BIT] = 1'b0;
      wr(ADDR_BAT, d);
      chk_val({3'h0, battery_threshold_code}, {3'h0, d[4:0]});
      chk_reg(ADDR_BAT, {3'b000, d[4:0]});
    end
    wr(16'h0047, 8'hff);
    wr(16'h004d, 8'hff);
    chk_reg(ADDR_ANA, ana_rd(ana_last));
    chk_mode(power_mode, PMU_ON);
    $display("test random fields done");
    wr(ADDR_IRQ_STAT, 8'h07);
    wr(ADDR_IRQ_MASK, 8'hff);
    wr(ADDR_ANA, 8'h13);
    chk_mode(power_mode, PMU_AUDIO);
    chk_bit(analog_supply_out_en, 1'b1);
    chk_bit(codec_power_en, 1'b1);
    chk_bit(digital_supply_out_en, 1'b1);
    settle(1);
    chk_bit(irq, 1'b1);
    chk_reg(ADDR_IRQ_STAT, 8'h04);
    wr(ADDR_IRQ_STAT, 8'h04);
    settle(1);
    chk_bit(irq, 1'b0);
    wr(ADDR_ANA, 8'h03);
    chk_mode(power_mode, PMU_ON);
    chk_bit(analog_supply_out_en, 1'b0);
    chk_bit(codec_power_en, 1'b0);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_IRQ_STAT, 8'h07);
    wr(ADDR_BAT, 8'h25);
    wr(ADDR_DIG, 8'h00);
    chk_mode(power_mode, PMU_OFF);
    chk_bit(digital_supply_out_en, 1'b0);
    chk_bit(battery_monitor_en, 1'b0);
    settle(1);
    chk_bit(irq, 1'b0);
    chk_reg(ADDR_IRQ_STAT, 8'h04);
    chk_reg(ADDR_DIG, 8'h00);
    wr(ADDR_ANA, 8'h13);
    settle(2);
    chk_mode(power_mode, PMU_OFF);
    chk_bit(analog_supply_out_en, 1'b0);
    chk_reg(ADDR_ANA, 8'h03);
    $display("test mode changes done");
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge sys_clk);
    wake_pin <= 1'b1;
    wait_mode(PMU_ON);
    chk_bit(digital_supply_out_en, 1'b1);
    settle(2);
    chk_bit(irq, 1'b1);
    chk_reg(ADDR_IRQ_STAT, 8'h05);
    chk_reg(ADDR_DIG, 8'h90);
    wr(ADDR_DIG, 8'h02);
    @(posedge sys_clk);
    wake_pin <= 1'b0;
    settle(8);
    chk_mode(power_mode, PMU_ON);
    chk_reg(ADDR_DIG, 8'h10);
    $display("test wake done");
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge sys_clk);
    battery_cmp_in <= 1'b1;
    wr(ADDR_BAT, 8'h3f);
    chk_bit(battery_monitor_en, 1'b1);
    chk_val({3'h0, battery_threshold_code}, 8'h1f);
    settle(START_CYC + 10);
    chk_reg(ADDR_BAT, 8'hbf);
    chk_bit(irq, 1'b0);
    @(posedge sys_clk);
    battery_cmp_in <= 1'b0;
    settle(8);
    chk_bit(irq, 1'b1);
    chk_reg(ADDR_BAT, 8'h3f);
    chk_reg(ADDR_IRQ_STAT, 8'h02);
    wr(ADDR_BAT, 8'h00);
    chk_bit(battery_monitor_en, 1'b0);
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge sys_clk);
    battery_cmp_in <= 1'b1;
    settle(6);
    @(posedge sys_clk);
    battery_cmp_in <= 1'b0;
    settle(8);
    chk_bit(irq, 1'b0);
    // Comparator drop inside the start-up time raises no event
    @(posedge sys_clk);
    battery_cmp_in <= 1'b1;
    settle(6);
    wr(ADDR_BAT, 8'h20);
    @(posedge sys_clk);
    battery_cmp_in <= 1'b0;
    settle(8);
    chk_bit(irq, 1'b0);
    chk_reg(ADDR_IRQ_STAT, 8'h00);
    chk_reg(ADDR_BAT, 8'h20);
    $display("test battery monitor done");
    close_out();
  end
endmodule
`default_nettype wire
